/* rtl/cwd_pkg.sv */
// Package of the configuration word decoder: map, field layout, codes.
// Assumes a 32-bit AXI4-Lite bus whose word index is the byte address over four.
package cwd_pkg;

  // Word indices; the byte address is four times the index.
  localparam logic [13:0] CWD_IDX_CFG  = 14'h2007;
  localparam logic [13:0] CWD_IDX_CTRL = 14'h2010;
  localparam logic [13:0] CWD_IDX_STAT = 14'h2011;

  localparam int          CWD_ADDR_W   = 16;
  localparam int          CWD_WORD_W   = 14;
  localparam logic [13:0] CWD_ERASED   = 14'h3FFF;
  localparam logic [1:0]  CWD_OKAY     = 2'h0;
  localparam logic [1:0]  CWD_SLVERR   = 2'h2;

  // Default field positions inside the word.
  localparam int CWD_OSC_LO   = 0;
  localparam int CWD_WDT_POS  = 3;
  localparam int CWD_PWT_POS  = 4;
  localparam int CWD_CP_LO    = 5;
  localparam int CWD_BOR_POS  = 7;
  localparam int CWD_RST_POS  = 8;
  localparam int CWD_DP_POS   = 9;

  // Control register: bit 0 requests an erase of the word.
  localparam int CWD_CTRL_ERASE = 0;

  // Memory technology behind the word.
  typedef enum logic [1:0] {
    CWD_TECH_ROM   = 2'b00,
    CWD_TECH_OTP   = 2'b01,
    CWD_TECH_EPROM = 2'b10,
    CWD_TECH_FLASH = 2'b11
  } cwd_tech_e;

  typedef enum logic [1:0] {
    CWD_CP_ALL    = 2'b00,
    CWD_CP_PART_B = 2'b01,
    CWD_CP_PART_A = 2'b10,
    CWD_CP_OFF    = 2'b11
  } cwd_cp_e;

  typedef enum logic [3:0] {
    CWD_OSC_LP       = 4'h0,
    CWD_OSC_XT       = 4'h1,
    CWD_OSC_HS       = 4'h2,
    CWD_OSC_RSVD     = 4'h3,
    CWD_OSC_INT      = 4'h4,
    CWD_OSC_INT_CLK  = 4'h5,
    CWD_OSC_EXT      = 4'h6,
    CWD_OSC_EXT_CLK  = 4'h7,
    CWD_OSC_RC       = 4'h8
  } cwd_osc_e;

  typedef enum logic {
    CWD_ST_LOAD = 1'b0,
    CWD_ST_HOLD = 1'b1
  } cwd_state_e;

  // Decoded mode controls handed to the rest of the device.
  typedef struct packed {
    cwd_cp_e  code_protect;
    logic     data_eeprom_protect;
    logic     brownout_reset_en;
    logic     powerup_timer_en;
    logic     external_reset_pin_en;
    logic     internal_reset_tied;
    logic     watchdog_en;
    cwd_osc_e osc_mode;
    logic     clock_output_en;
  } cwd_modes_s;

endpackage

/* rtl/cwd_decoder.sv */
// Configuration word store and decoder with an AXI4-Lite programming port.
// Assumes aresetn is the power-on reset and prog_mode comes from the
// programming entry logic, synchronous to aclk.
//
// Notes on behaviour
// R1: The word sits at program address 2007h; the programmer writes it there.
// R2: The word is reachable only in programming mode, never by running code.
// R3: Programmed bits read as 0, erased bits read as 1.
// R4: Modes are selected at power-up from the stored word.
// R5: In one-time parts a bit programmed to 0 never returns to 1.
// R6: Windowed parts erase the word only by UV erase, clearing program memory too.
// R7: Flash parts erase and reprogram the word any number of times.
// R8: Two-bit protect: 11 off, 00 all, 10 and 01 partial levels.
// R9: Single protect bit: 1 off, 0 protection on.
// R10: Data EEPROM protect: 1 unprotected, 0 protected.
// R11: Brown-out reset enable: 1 on, 0 off.
// R12: Brown-out reset enabled forces the power-up timer on.
// R13: Power-up timer enable is active low.
// R14: Reset pin bit: 1 external reset, 0 digital I/O with reset tied high.
// R15: Watchdog enable: 1 on, 0 off.
// R16: Two-bit oscillator: 11 RC, 10 HS crystal, 01 crystal, 00 low power.
// R17: Three-bit oscillator codes map EXT/INT RC, clock out, reserved, crystals.
// R18: Unimplemented word positions always read as 1.
// R19: Word captured once after power-on reset; decoded modes held until next.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps

module cwd_decoder #(
  parameter cwd_pkg::cwd_tech_e TECH      = cwd_pkg::CWD_TECH_FLASH,
  parameter bit                 WIDE_OSC  = 1'b1,
  parameter bit                 SINGLE_CP = 1'b0,
  parameter logic [13:0]        INIT_WORD = 14'h3FFF,
  parameter logic [13:0]        IMPL_MASK = 14'h03FF,
  parameter int                 OSC_LO    = cwd_pkg::CWD_OSC_LO,
  parameter int                 WDT_POS   = cwd_pkg::CWD_WDT_POS,
  parameter int                 PWT_POS   = cwd_pkg::CWD_PWT_POS,
  parameter int                 CP_LO     = cwd_pkg::CWD_CP_LO,
  parameter int                 BOR_POS   = cwd_pkg::CWD_BOR_POS,
  parameter int                 RST_POS   = cwd_pkg::CWD_RST_POS,
  parameter int                 DP_POS    = cwd_pkg::CWD_DP_POS
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [15:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [15:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               prog_mode,
  output cwd_pkg::cwd_modes_s     modes,
  output logic                    modes_valid,
  output logic                    prog_mem_erase
);
  import cwd_pkg::*;

  // Nonvolatile word and the captured, decoded modes.
  logic [13:0] cfg_q;
  logic [13:0] cfg_d;
  cwd_modes_s  modes_q;
  cwd_modes_s  modes_d;
  cwd_state_e  state_q;
  logic        erase_q;

  // Write channel holding registers.
  logic        aw_have_q;
  logic [13:0] aw_idx_q;
  logic        w_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  // Read channel registers.
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  logic        wr_go;
  logic        wr_cfg;
  logic        wr_ctrl;
  logic        wr_ok;
  logic        do_erase;
  logic [13:0] lane_m;
  logic [13:0] new_word;
  logic [13:0] rd_idx;
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;

  // Address and data are accepted independently; both stall while a
  // response waits, so at most one write is in flight.
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign modes          = modes_q;
  assign modes_valid    = (state_q == CWD_ST_HOLD);
  assign prog_mem_erase = erase_q;

  // Write address capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= 14'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[15:2];
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  // Write data capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  // Write decode. Outside programming mode the word and control register
  // refuse every access, so running code cannot touch them.
  assign wr_go   = aw_have_q && w_have_q && !bvalid_q;
  assign wr_cfg  = (aw_idx_q == CWD_IDX_CFG);  // see R1
  assign wr_ctrl = (aw_idx_q == CWD_IDX_CTRL);
  assign do_erase = wr_go && wr_ctrl && prog_mode && wstrb_q[0]
                    && wdata_q[CWD_CTRL_ERASE]
                    && (TECH == CWD_TECH_EPROM || TECH == CWD_TECH_FLASH);
  always_comb begin
    wr_ok = 1'b0;
    if (prog_mode) begin  // see R2
      if (wr_cfg) begin
        wr_ok = (TECH != CWD_TECH_ROM);
      end else if (wr_ctrl) begin
        wr_ok = (TECH == CWD_TECH_EPROM || TECH == CWD_TECH_FLASH)
                || !(wstrb_q[0] && wdata_q[CWD_CTRL_ERASE]);
      end
    end
  end

  // Byte lanes 0 and 1 cover the fourteen word bits.
  assign lane_m = {{6{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // Next word value. One-time and windowed cells can only be pulled from
  // 1 to 0 by programming; flash cells take the written value outright.
  always_comb begin
    new_word = cfg_q;
    case (TECH)
      CWD_TECH_OTP, CWD_TECH_EPROM: begin
        new_word = cfg_q & (wdata_q[13:0] | ~lane_m);  // see R5
      end
      CWD_TECH_FLASH: begin
        new_word = (cfg_q & ~lane_m) | (wdata_q[13:0] & lane_m);  // see R7
      end
      default: begin
        new_word = cfg_q;
      end
    endcase
  end

  // Erase returns the word to all ones; unimplemented bits stay at 1.
  always_comb begin
    cfg_d = cfg_q;
    if (do_erase) begin
      cfg_d = CWD_ERASED;  // see R6 see R7
    end else if (wr_go && wr_cfg && wr_ok) begin
      cfg_d = new_word;
    end
    cfg_d = cfg_d | ~IMPL_MASK;  // see R18
  end

  // The word models nonvolatile cells: its power-up content is INIT_WORD,
  // standing in for what the cells held when power was removed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= INIT_WORD | ~IMPL_MASK;  // see R18
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // A windowed erase also wipes program memory; flash erase does not.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_q <= 1'b0;
    end else begin
      erase_q <= do_erase && (TECH == CWD_TECH_EPROM);  // see R6
    end
  end

  // Write response, held until the master takes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= CWD_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? CWD_OKAY : CWD_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read decode. The word reads back raw: programmed bits as 0 and
  // erased or unimplemented bits as 1.
  assign rd_idx = s_axi_araddr[15:2];
  always_comb begin
    rd_data = 32'h00000000;
    rd_resp = CWD_OKAY;
    if (rd_idx == CWD_IDX_CFG) begin
      if (prog_mode) begin
        rd_data = {18'h00000, cfg_q};  // see R3 see R2
      end else begin
        rd_resp = CWD_SLVERR;
      end
    end else if (rd_idx == CWD_IDX_STAT) begin
      rd_data = {28'h0000000, TECH, modes_valid, prog_mode};
    end else if (rd_idx == CWD_IDX_CTRL) begin
      rd_resp = prog_mode ? CWD_OKAY : CWD_SLVERR;
    end else begin
      rd_resp = CWD_SLVERR;
    end
  end

  // Read response, one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= CWD_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data;
      rresp_q  <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Decode of the stored word into mode controls.
  always_comb begin
    modes_d = '0;
    if (SINGLE_CP) begin
      modes_d.code_protect = cfg_q[CP_LO] ? CWD_CP_OFF : CWD_CP_ALL;  // see R9
    end else begin
      modes_d.code_protect = cwd_cp_e'(cfg_q[CP_LO +: 2]);  // see R8
    end
    modes_d.data_eeprom_protect = !cfg_q[DP_POS];  // see R10
    modes_d.brownout_reset_en   = cfg_q[BOR_POS];  // see R11
    // Brown-out reset cannot work without the power-up delay behind it.
    modes_d.powerup_timer_en    = !cfg_q[PWT_POS]  // see R13
                                  || cfg_q[BOR_POS];  // see R12
    modes_d.external_reset_pin_en = cfg_q[RST_POS];  // see R14
    modes_d.internal_reset_tied   = !cfg_q[RST_POS];  // see R14
    modes_d.watchdog_en           = cfg_q[WDT_POS];  // see R15
    if (WIDE_OSC) begin
      modes_d.osc_mode = cwd_osc_e'({1'b0, cfg_q[OSC_LO +: 3]});  // see R17
      modes_d.clock_output_en = cfg_q[OSC_LO + 2] && cfg_q[OSC_LO];  // see R17
    end else begin
      case (cfg_q[OSC_LO +: 2])  // see R16
        2'b11:   modes_d.osc_mode = CWD_OSC_RC;
        2'b10:   modes_d.osc_mode = CWD_OSC_HS;
        2'b01:   modes_d.osc_mode = CWD_OSC_XT;
        default: modes_d.osc_mode = CWD_OSC_LP;
      endcase
    end
  end

  // Capture once at the first edge after reset release, then hold.
  // Later reprogramming never reaches the modes: power-on reset reloads INIT_WORD before the next capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CWD_ST_LOAD;
      modes_q <= '0;
    end else begin
      case (state_q)
        CWD_ST_LOAD: begin
          modes_q <= modes_d;  // see R4 see R19
          state_q <= CWD_ST_HOLD;
        end
        CWD_ST_HOLD: begin
          state_q <= CWD_ST_HOLD;  // see R19
        end
        default: begin
          state_q <= CWD_ST_LOAD;
        end
      endcase
    end
  end

endmodule

/* verification/cwd_decoder_assertions.sv */
// Checker for the configuration word decoder; bound to every decoder instance.
// Assumes the decoder's own port names and the cwd_pkg types.
`timescale 1ns/100ps
module cwd_decoder_assertions (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic [15:0]         s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                prog_mode,
  input wire cwd_pkg::cwd_modes_s modes,
  input wire logic                modes_valid,
  input wire logic                prog_mem_erase
);
  import cwd_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A read of the word is taken on this edge.
  sequence word_read_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[15:2] == CWD_IDX_CFG;
  endsequence
  // Decoded modes on offer for two edges running.
  sequence modes_on_s;
    modes_valid ##1 modes_valid;
  endsequence
  word_hidden_a:
    assert property (word_read_s ##0 !prog_mode |=> s_axi_rresp == CWD_SLVERR
                     && s_axi_rdata == 32'h0) else $error("word seen outside programming");
  unimpl_ones_a:
    assert property (word_read_s ##0 prog_mode |=> s_axi_rdata[31:10] == 22'h0000F)
    else $error("unimplemented bits not one");
  write_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  read_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  modes_frozen_a:
    assert property (modes_on_s |-> $stable(modes)) else $error("modes changed after capture");
  modes_ready_a:
    assert property ($rose(aresetn) |-> ##[1:2] modes_valid) else $error("modes not captured");
  bor_timer_a:
    assert property (modes_valid && modes.brownout_reset_en |-> modes.powerup_timer_en)
    else $error("timer not forced by brown-out");
  reset_tie_a:
    assert property (modes_valid |-> modes.internal_reset_tied != modes.external_reset_pin_en)
    else $error("reset pin and tie disagree");
  erase_pulse_a:
    assert property (prog_mem_erase |=> !prog_mem_erase) else $error("erase pulse too long");
endmodule

bind cwd_decoder cwd_decoder_assertions chk_u (.*);

/* verification/cwd_programmer_model.sv */
// Device programmer model on the AXI4-Lite port; also drives programming mode.
// Assumes callers enter access right after a rising edge of aclk.
`timescale 1ns/100ps
module cwd_programmer_model (
  input  wire logic        aclk,
  output logic [15:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [15:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  output logic             prog_mode,
  output logic             hung
);
  int stall = 0; // Cycles of held-back bready or rready, to act as a slow programmer.
  // Idle at time zero: all strobes on, outside programming mode.
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
    {s_axi_wstrb, prog_mode, hung} = 6'h3C;
  end
  // One transfer; a released address or data line shows its inverse, so a
  // stale value can never be mistaken for a live one.
  task automatic access(input bit wr, input logic [15:0] a, inout logic [31:0] d,
                        output logic [1:0] r);
    int n;
    bit ad;
    bit w;
    bit b;
    n = 0;
    b = 1'b0;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
    end
    while (!b && n < 60) begin
      {s_axi_bready, s_axi_rready} <= {2{n >= stall}} & {wr, !wr};
      @(negedge aclk);
      ad = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
      w  = s_axi_wvalid && s_axi_wready;
      b  = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
      r  = wr ? s_axi_bresp : s_axi_rresp;
      d  = wr ? d : s_axi_rdata;
      @(posedge aclk);
      if (ad) begin
        {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
        {s_axi_awaddr, s_axi_araddr}   <= ~{a, a};
      end
      if (w) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
      n++;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    hung <= !b;
  endtask
endmodule

/* verification/cwd_decoder_test.sv */
// Bench for the configuration word decoder: preset-word decode table, then bus cases.
// Assumes cwd_pkg, the decoder, the programmer model and the bound checker.
`timescale 1ns/100ps
module cwd_decoder_test;
  import cwd_pkg::*;
  localparam int N = 12;
  localparam logic [15:0] A_CFG = {CWD_IDX_CFG, 2'h0};
  localparam logic [15:0] A_CTL = {CWD_IDX_CTRL, 2'h0};
  // Preset words; rows 8 up use the narrow oscillator field and one protect bit.
  localparam logic [13:0] ROW_W [N] = '{14'h3F70, 14'h3C99, 14'h3E4A, 14'h3D33, 14'h3FEC,
    14'h3C05, 14'h3EB6, 14'h3D4F, 14'h3F78, 14'h3C81, 14'h3E6A, 14'h3DCB};
  localparam cwd_osc_e OSC_W [8] = '{CWD_OSC_LP, CWD_OSC_XT, CWD_OSC_HS, CWD_OSC_RSVD,
    CWD_OSC_INT, CWD_OSC_INT_CLK, CWD_OSC_EXT, CWD_OSC_EXT_CLK};
  localparam cwd_osc_e OSC_N [4] = '{CWD_OSC_LP, CWD_OSC_XT, CWD_OSC_HS, CWD_OSC_RC};
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [15:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, val;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic         prog_mode, modes_valid, prog_mem_erase, hung;
  cwd_modes_s   modes, e;
  cwd_modes_s   modes_a [N];
  logic [N-1:0] erase_a;
  int           mismatches = 0, comparisons = 0, erase_n = 0, flash_n = 0;

  cwd_programmer_model prog_u (.*);
  cwd_decoder dut_u (.*);
  // One decoder per preset word; row 1 sits on windowed erasable memory.
  for (genvar i = 0; i < N; i++) begin : g_row
    cwd_decoder #(.TECH(cwd_tech_e'(i == 1 ? 2'h2 : 2'h3)), .WIDE_OSC(i < 8),
      .SINGLE_CP(i >= 8), .INIT_WORD(ROW_W[i])) row_u (.*, .s_axi_awready(), .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
      .s_axi_rvalid(), .modes(modes_a[i]), .modes_valid(), .prog_mem_erase(erase_a[i]));
  end

  // Half-period toggle gives 200 MHz.
  always #2.5 aclk = ~aclk;
  // Erase pulses are counted mid-cycle, clear of the edge that moves them.
  always @(negedge aclk) begin
    erase_n = erase_n + int'(erase_a[1]);
    flash_n = flash_n + int'(prog_mem_erase);
  end
  // A bus wait that ran out ends the run.
  always @(posedge hung) begin
    mismatches++;
    complete_run();
  end

  function automatic cwd_modes_s exp_of(input logic [13:0] w, input bit wide);
    cwd_modes_s m;
    // Narrow rows are also the single-protect rows, so only bit 5 counts there.
    m.code_protect          = cwd_cp_e'(wide ? w[6:5] : {2{w[5]}});
    m.data_eeprom_protect   = !w[9];
    m.brownout_reset_en     = w[7];
    m.powerup_timer_en      = !w[4] || w[7];
    m.external_reset_pin_en = w[8];
    m.internal_reset_tied   = !w[8];
    m.watchdog_en           = w[3];
    m.osc_mode              = wide ? OSC_W[w[2:0]] : OSC_N[w[1:0]];
    m.clock_output_en       = wide && w[2] && w[0];
    return m;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus transfer with its answer; read data is compared on reads only.
  task automatic bus(input bit wr, input logic [15:0] a, input logic [31:0] v,
                     input logic [1:0] er, input logic [31:0] ed);
    val = v;
    prog_u.access(wr, a, val, resp);
    chk("response", 32'(resp), 32'(er));
    if (!wr) chk("read data", val, ed);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("valid in reset", 32'(modes_valid), 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    for (int i = 0; i < N; i++) begin
      e = exp_of(ROW_W[i], i < 8);
      chk($sformatf("row %0d", i), 32'(modes_a[i]), 32'(e));
    end
    chk("modes", 32'(modes), 32'(exp_of(14'h3FFF, 1'b1)));
    bus(1'b0, A_CFG, 32'h0, CWD_SLVERR, 32'h0);
    bus(1'b1, A_CFG, 32'h0, CWD_SLVERR, 32'h0);
    prog_u.prog_mode <= 1'b1;
    bus(1'b0, A_CFG, 32'h0, CWD_OKAY, 32'h3FFF);
    prog_u.stall = 3;
    bus(1'b1, A_CFG, 32'h0, CWD_OKAY, 32'h0);
    bus(1'b0, A_CFG, 32'h0, CWD_OKAY, 32'h3C00);
    chk("modes held", 32'(modes), 32'(exp_of(14'h3FFF, 1'b1)));
    bus(1'b1, A_CTL, 32'h1, CWD_OKAY, 32'h0);
    bus(1'b0, A_CFG, 32'h0, CWD_OKAY, 32'h3FFF);
    bus(1'b1, A_CFG, 32'h285, CWD_OKAY, 32'h0);
    bus(1'b0, A_CFG, 32'h0, CWD_OKAY, 32'h3E85);
    bus(1'b0, 16'h0000, 32'h0, CWD_SLVERR, 32'h0);
    chk("windowed erase", 32'(erase_n), 32'h1);
    chk("flash erase", 32'(flash_n), 32'h0);
    prog_u.prog_mode <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("valid in reset", 32'(modes_valid), 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("modes again", 32'(modes), 32'(exp_of(14'h3FFF, 1'b1)));
    complete_run();
  end
endmodule
